// [verilog/htc_pkg.sv]
// Package for the hypervisor trap-control block: types, field positions,
// encodings and reset values.
// Assumes one core clock; all requests come from logic on that clock.
package htc_pkg;

    // ----------------------------------------------------------------
    // Levels and request kinds
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {HTC_USER, HTC_KERNEL, HTC_HYP} htc_level_e;

    typedef enum logic [2:0] {
        HTC_OP_NONE,
        HTC_OP_SYSREG,
        HTC_OP_VECTOR,
        HTC_OP_FP,
        HTC_OP_HVC,
        HTC_OP_POU_CMO,
        HTC_OP_EXC_ROUTE,
        HTC_OP_EXC_RET
    } htc_op_e;

    typedef struct packed {
        logic [3:0] coproc;
        logic [2:0] opc1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opc2;
    } htc_enc_s;

    typedef struct packed {
        logic       valid;
        htc_op_e    op;
        htc_level_e level;
        logic       is_read;
        htc_enc_s   enc;
        logic [31:0] wdata;
        logic       kernel_trap;
        logic       is_coproc_access_control_reg;
        logic       is_trace;
        logic       trace_user_denied;
        logic       is_fp_sysreg;
        logic       is_memctl;
    } htc_req_s;

    typedef struct packed {
        logic        valid;
        logic        hyp_trap;
        logic        undef_hyp;
        logic        undef_local;
        logic        suppress;
        logic        proceed;
        logic        rd_valid;
        logic [31:0] rdata;
        logic        route_hyp;
        logic        illegal_ret;
    } htc_resp_s;

    typedef struct packed {
        logic       coproc_access_trap;
        logic       trace_trap;
        logic       vector_only_trap;
        logic       fp_trap_companion;
        logic       fp_trap;
        logic       memctl_read_trap;
        logic       hypcall_disable;
        logic       general_exception_trap;
        logic       memctl_write_trap;
        logic       pou_cache_trap;
        htc_resp_s  resp;
        logic       eff_mpu_en;
        logic [2:0] eff_route_ovr;
        logic [3:0] eff_dbg_trap;
        logic       virq_disable;
    } htc_state_s;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FT_COPROC_BIT = 31;
    localparam int FT_TRACE_BIT  = 20;
    localparam int FT_VECTOR_BIT = 15;
    localparam int FT_FPCOMP_BIT = 11;
    localparam int FT_FP_BIT     = 10;
    localparam int CFG_MRD_BIT   = 30;
    localparam int CFG_HCD_BIT   = 29;
    localparam int CFG_GEN_BIT   = 27;
    localparam int CFG_MWR_BIT   = 26;
    localparam int CFG_POU_BIT   = 24;

    localparam logic [31:0] FT_RES1_MASK = 32'h0000_33FF;
    localparam logic        FIELD_RESET  = 1'h0;
    localparam logic [2:0]  ROUTE_ALL    = 3'h7;
    localparam logic [3:0]  DBG_ALL      = 4'hF;

    // Feature options of this core
    localparam logic HAS_VECTOR   = 1'h1;
    localparam logic VECTOR_IS_RW = 1'h1;

    // ----------------------------------------------------------------
    // Register encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] FT_COPROC = 4'hF;
    localparam logic [2:0] FT_OPC1   = 3'h4;
    localparam logic [3:0] FT_CRN    = 4'h1;
    localparam logic [3:0] FT_CRM    = 4'h1;
    localparam logic [2:0] FT_OPC2   = 3'h2;
    localparam logic [3:0] CFG_COPROC = 4'hF;
    localparam logic [2:0] CFG_OPC1   = 3'h4;
    localparam logic [3:0] CFG_CRN    = 4'h1;
    localparam logic [3:0] CFG_CRM    = 4'h1;
    localparam logic [2:0] CFG_OPC2   = 3'h0;

endpackage

// [verilog/htc_enc_match.sv]
// Encoding comparator for one system register.
// Assumes the encoding fields arrive already split out of the instruction.
`timescale 1ns/1ps
module htc_enc_match #(
    parameter logic [3:0] COPROC = 4'h0,
    parameter logic [2:0] OPC1   = 3'h0,
    parameter logic [3:0] CRN    = 4'h0,
    parameter logic [3:0] CRM    = 4'h0,
    parameter logic [2:0] OPC2   = 3'h0
) (
    // Encoding in
    input  wire htc_pkg::htc_enc_s enc_i,
    // Hit out
    output logic                   hit_o
);
    import htc_pkg::*;

    assign hit_o = (enc_i.coproc == COPROC) && (enc_i.opc1 == OPC1) &&
                   (enc_i.crn == CRN) && (enc_i.crm == CRM) && (enc_i.opc2 == OPC2);

endmodule

// [verilog/htc_trap_ctrl.sv]
// Hypervisor trap-control block: feature-trap and configuration registers
// and the trap decisions made from them.
// Assumes the pipeline presents one classified request a cycle, on the core clock.
//
// What this block does
// - Coprocessor-access trap diverts kernel accesses to hypervisor
// - Trace trap diverts trace register accesses
// - Lower-level trap is hyp trap, hyp gives undef
// - Trapped sysreg access causes no side-effects
// - Vector-only trap applies while fp trap clear
// - Vector-only bit reads one if absent
// - Companion fp bit is ignored
// - Fp trap diverts vector and fp accesses
// - Fp trap covers instructions, register views, sysregs
// - Writable trap fields reset to zero
// - Feature register decoded and read/written by encoding
// - Memory-control read trap for kernel reads
// - Memory-control write trap for kernel writes
// - Hypervisor-call disable makes call undefined
// - General trap routes kernel exceptions to hypervisor
// - General trap forces protection off, overrides on
// - General trap disables virtual irqs, illegal returns
// - Unification trap diverts kernel cache maintenance
// - User cache maintenance undefined, takes priority
`timescale 1ns/1ps
module htc_trap_ctrl (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // Pipeline request
    input  wire htc_pkg::htc_req_s  req_i,
    // Raw controls to be overridden
    input  wire logic               system_control_reg_m_i,
    input  wire logic [2:0]         route_ovr_i,
    input  wire logic [3:0]         dbg_trap_i,
    // Decision out
    output htc_pkg::htc_resp_s      resp_o,
    // Effective controls
    output logic                    eff_mpu_en_o,
    output logic [2:0]              eff_route_ovr_o,
    output logic [3:0]              eff_dbg_trap_o,
    output logic                    virq_disable_o
);
    import htc_pkg::*;

    // ----------------------------------------------------------------
    // State and decode
    // ----------------------------------------------------------------
    htc_state_s  st;
    htc_state_s  next_st;
    logic        hit_ft;
    logic        hit_cfg;
    logic        lower;
    logic        kern;
    logic        user;
    logic        trap;
    logic        undef_l;
    logic        vec_eff;
    logic [31:0] ft_rd;
    logic [31:0] cfg_rd;

    htc_enc_match #(
        .COPROC (FT_COPROC),
        .OPC1   (FT_OPC1),
        .CRN    (FT_CRN),
        .CRM    (FT_CRM),
        .OPC2   (FT_OPC2)
    ) u_ft_match (
        .enc_i (req_i.enc),
        .hit_o (hit_ft)
    );

    htc_enc_match #(
        .COPROC (CFG_COPROC),
        .OPC1   (CFG_OPC1),
        .CRN    (CFG_CRN),
        .CRM    (CFG_CRM),
        .OPC2   (CFG_OPC2)
    ) u_cfg_match (
        .enc_i (req_i.enc),
        .hit_o (hit_cfg)
    );

    // ----------------------------------------------------------------
    // Read views
    // ----------------------------------------------------------------
    always_comb begin
        // Bit reads one with no vector unit, zero when not writable
        if (!HAS_VECTOR) begin
            vec_eff = 1'h1;
        end else if (!VECTOR_IS_RW) begin
            vec_eff = 1'h0;
        end else begin
            vec_eff = st.vector_only_trap;
        end
        ft_rd = FT_RES1_MASK;
        ft_rd[FT_COPROC_BIT] = st.coproc_access_trap;
        ft_rd[FT_TRACE_BIT]  = st.trace_trap;
        ft_rd[FT_VECTOR_BIT] = vec_eff;
        ft_rd[FT_FPCOMP_BIT] = st.fp_trap_companion;
        ft_rd[FT_FP_BIT]     = st.fp_trap;
        cfg_rd = '0;
        cfg_rd[CFG_MRD_BIT] = st.memctl_read_trap;
        cfg_rd[CFG_HCD_BIT] = st.hypcall_disable;
        cfg_rd[CFG_GEN_BIT] = st.general_exception_trap;
        cfg_rd[CFG_MWR_BIT] = st.memctl_write_trap;
        cfg_rd[CFG_POU_BIT] = st.pou_cache_trap;
    end

    // ----------------------------------------------------------------
    // Decision logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.resp = '0;
        trap    = 1'h0;
        undef_l = 1'h0;
        lower   = (req_i.level != HTC_HYP);
        kern    = (req_i.level == HTC_KERNEL);
        user    = (req_i.level == HTC_USER);
        if (req_i.valid) begin
            case (req_i.op)
                HTC_OP_SYSREG: begin
                    if (hit_ft || hit_cfg) begin
                        if (lower) begin
                            undef_l = 1'h1;
                        end else if (req_i.is_read) begin
                            next_st.resp.rd_valid = 1'h1;
                            next_st.resp.rdata    = hit_ft ? ft_rd : cfg_rd;
                        end else if (hit_ft) begin
                            // New value seen by the next instruction
                            next_st.coproc_access_trap = req_i.wdata[FT_COPROC_BIT];
                            next_st.trace_trap         = req_i.wdata[FT_TRACE_BIT];
                            if (VECTOR_IS_RW && HAS_VECTOR) begin
                                next_st.vector_only_trap = req_i.wdata[FT_VECTOR_BIT];
                            end
                            next_st.fp_trap_companion  = req_i.wdata[FT_FPCOMP_BIT];
                            next_st.fp_trap            = req_i.wdata[FT_FP_BIT];
                        end else begin
                            next_st.memctl_read_trap       = req_i.wdata[CFG_MRD_BIT];
                            next_st.hypcall_disable        = req_i.wdata[CFG_HCD_BIT];
                            next_st.general_exception_trap = req_i.wdata[CFG_GEN_BIT];
                            next_st.memctl_write_trap      = req_i.wdata[CFG_MWR_BIT];
                            next_st.pou_cache_trap         = req_i.wdata[CFG_POU_BIT];
                        end
                    end else if (!req_i.kernel_trap) begin
                        if (req_i.is_coproc_access_control_reg && kern && st.coproc_access_trap) begin
                            trap = 1'h1;
                        end
                        if (req_i.is_trace) begin
                            if (user && req_i.trace_user_denied) begin
                                undef_l = 1'h1;
                            end else if (st.trace_trap) begin
                                trap = 1'h1;
                            end
                        end
                        if (req_i.is_fp_sysreg && st.fp_trap) begin
                            trap = 1'h1;
                        end
                        if (req_i.is_memctl && kern) begin
                            if (req_i.is_read && st.memctl_read_trap) begin
                                trap = 1'h1;
                            end
                            if (!req_i.is_read && st.memctl_write_trap) begin
                                trap = 1'h1;
                            end
                        end
                    end
                    // No side-effects may escape a diverted access
                    next_st.resp.suppress = trap || undef_l;
                end
                HTC_OP_VECTOR: begin
                    // Fp trap wins; vector-only bit only while it is clear
                    if (!req_i.kernel_trap && (st.fp_trap || vec_eff)) begin
                        trap = 1'h1;
                    end
                end
                HTC_OP_FP: begin
                    if (!req_i.kernel_trap && st.fp_trap) begin
                        trap = 1'h1;
                    end
                end
                HTC_OP_HVC: begin
                    if (user || st.hypcall_disable) begin
                        undef_l = 1'h1;
                    end
                end
                HTC_OP_POU_CMO: begin
                    if (user) begin
                        undef_l = 1'h1;
                    end else if (kern && st.pou_cache_trap) begin
                        trap = 1'h1;
                    end
                end
                HTC_OP_EXC_ROUTE: begin
                    next_st.resp.route_hyp = st.general_exception_trap;
                end
                HTC_OP_EXC_RET: begin
                    next_st.resp.illegal_ret = st.general_exception_trap;
                end
                default: begin
                end
            endcase
            next_st.resp.valid       = 1'h1;
            next_st.resp.hyp_trap    = trap && lower;
            next_st.resp.undef_hyp   = trap && !lower;
            next_st.resp.undef_local = undef_l;
            next_st.resp.proceed     = !trap && !undef_l && !next_st.resp.illegal_ret;
        end
        // Overrides while the general trap is on
        next_st.eff_mpu_en    = system_control_reg_m_i && !st.general_exception_trap;
        next_st.eff_route_ovr = st.general_exception_trap ? ROUTE_ALL : route_ovr_i;
        next_st.eff_dbg_trap  = st.general_exception_trap ? DBG_ALL : dbg_trap_i;
        next_st.virq_disable  = st.general_exception_trap;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign resp_o          = st.resp;
    assign eff_mpu_en_o    = st.eff_mpu_en;
    assign eff_route_ovr_o = st.eff_route_ovr;
    assign eff_dbg_trap_o  = st.eff_dbg_trap;
    assign virq_disable_o  = st.virq_disable;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_COPROC_ACCESS_CONTROL_REG_TRAP: assert property (req_i.valid && req_i.op == HTC_OP_SYSREG && req_i.is_coproc_access_control_reg
        && req_i.level == HTC_KERNEL && !req_i.kernel_trap && !hit_ft && !hit_cfg
        && st.coproc_access_trap |=> resp_o.hyp_trap && resp_o.suppress)
        else $error("kernel access to coprocessor control not trapped");
    AST_TRACE_TRAP: assert property (req_i.valid && req_i.op == HTC_OP_SYSREG && req_i.is_trace
        && req_i.level == HTC_KERNEL && !req_i.kernel_trap && !hit_ft && !hit_cfg
        && st.trace_trap |=> resp_o.hyp_trap && !resp_o.proceed)
        else $error("trace access not trapped");
    AST_HYP_UNDEF: assert property (resp_o.valid |-> !(resp_o.hyp_trap && resp_o.undef_hyp)
        && !(resp_o.undef_hyp && (resp_o.hyp_trap || resp_o.undef_local)))
        else $error("trap kinds overlap");
    AST_HYP_LEVEL: assert property (req_i.valid && req_i.level == HTC_HYP |=> !resp_o.hyp_trap)
        else $error("hyp trap raised from hypervisor level");
    AST_SUPPRESS: assert property (resp_o.valid && (resp_o.hyp_trap || resp_o.undef_hyp)
        && $past(req_i.op) == HTC_OP_SYSREG |-> resp_o.suppress)
        else $error("side-effects not suppressed");
    AST_VECTOR: assert property (req_i.valid && req_i.op == HTC_OP_VECTOR && !req_i.kernel_trap
        && !st.fp_trap && !vec_eff && req_i.level != HTC_HYP |=> resp_o.proceed)
        else $error("vector instruction trapped with both bits clear");
    AST_FP: assert property (req_i.valid && req_i.op == HTC_OP_FP && !req_i.kernel_trap
        && st.fp_trap && req_i.level == HTC_USER |=> resp_o.hyp_trap)
        else $error("fp instruction not trapped");
    AST_MEMCTL: assert property (req_i.valid && req_i.op == HTC_OP_SYSREG && req_i.is_memctl
        && req_i.level == HTC_KERNEL && !req_i.kernel_trap && !hit_ft && !hit_cfg
        && (req_i.is_read ? st.memctl_read_trap : st.memctl_write_trap) |=> resp_o.hyp_trap)
        else $error("memory-control access not trapped");
    AST_HVC: assert property (req_i.valid && req_i.op == HTC_OP_HVC && st.hypcall_disable
        |=> resp_o.undef_local && !resp_o.proceed)
        else $error("disabled hypervisor call not undefined");
    AST_ROUTE: assert property (req_i.valid && req_i.op == HTC_OP_EXC_ROUTE
        |=> resp_o.route_hyp == $past(st.general_exception_trap))
        else $error("exception routing wrong");
    AST_OVERRIDE: assert property (st.general_exception_trap ##1 st.general_exception_trap
        |-> !eff_mpu_en_o && eff_route_ovr_o == ROUTE_ALL && virq_disable_o)
        else $error("general trap overrides missing");
    AST_ILLEGAL_RET: assert property (req_i.valid && req_i.op == HTC_OP_EXC_RET
        && st.general_exception_trap |=> resp_o.illegal_ret && !resp_o.proceed)
        else $error("return to kernel level not made illegal");
    AST_POU_TRAP: assert property (req_i.valid && req_i.op == HTC_OP_POU_CMO && kern
        && st.pou_cache_trap |=> resp_o.hyp_trap && !resp_o.proceed)
        else $error("kernel cache maintenance not trapped");
    AST_POU: assert property (req_i.valid && req_i.op == HTC_OP_POU_CMO && req_i.level == HTC_USER
        |=> resp_o.undef_local && !resp_o.hyp_trap)
        else $error("user cache maintenance not undefined first");
    AST_FT_RES1: assert property (resp_o.rd_valid && $past(hit_ft) |->
        (resp_o.rdata & FT_RES1_MASK) == FT_RES1_MASK)
        else $error("feature register reserved-one bits not read as one");
    AST_WRITE_READ: assert property (req_i.valid && req_i.op == HTC_OP_SYSREG && hit_ft
        && req_i.level == HTC_HYP && !req_i.is_read ##1 req_i.valid && req_i.op == HTC_OP_SYSREG
        && hit_ft && req_i.level == HTC_HYP && req_i.is_read
        |=> resp_o.rd_valid && resp_o.rdata[FT_FP_BIT] == $past(req_i.wdata[FT_FP_BIT], 2))
        else $error("write not visible to next instruction");

    COV_TRAP: cover property (resp_o.hyp_trap);
    COV_UNDEF_HYP: cover property (resp_o.undef_hyp);
    COV_READ: cover property (resp_o.rd_valid);
    COV_ROUTE: cover property (resp_o.route_hyp);
    COV_ILLEGAL_RET: cover property (resp_o.illegal_ret);

endmodule

// [verif/htc_pipe_model.sv]
// Pipeline model: issues one or two classified requests, returns the decision to the last.
// Assumes the decision is registered on the same edge that takes the request.
`timescale 1ns/1ps
module htc_pipe_model (
    // Clock
    input  wire logic               clk_i,
    // Decision in
    input  wire htc_pkg::htc_resp_s resp_i,
    // Request out
    output htc_pkg::htc_req_s       req_o
);
    import htc_pkg::*;

    initial req_o = '0;

    // Request held over one taking edge, answer read after it
    task automatic send(input htc_req_s r, output htc_resp_s rs);
        @(posedge clk_i);
        req_o <= r;
        @(posedge clk_i);
        req_o <= '0;
        #1;
        rs = resp_i;
    endtask

    // Two requests on consecutive edges, answer to the second read after it
    task automatic send_pair(input htc_req_s r1, input htc_req_s r2, output htc_resp_s rs);
        @(posedge clk_i);
        req_o <= r1;
        @(posedge clk_i);
        req_o <= r2;
        @(posedge clk_i);
        req_o <= '0;
        #1;
        rs = resp_i;
    endtask
endmodule

// [verif/htc_trap_ctrl_bench.sv]
// Testbench for the trap-control block: register access and trap decisions.
// Assumes the pipeline model drives requests; raw controls are held fixed.
`timescale 1ns/1ps
module htc_trap_ctrl_bench;
    import htc_pkg::*;

    logic       clk_i = 1'h0;
    logic       rst_n_i = 1'h0;
    logic       system_control_reg_m = 1'h1;
    logic [2:0] route_ovr = 3'h2;
    logic [3:0] dbg_trap = 4'h5;
    htc_req_s   req;
    htc_resp_s  resp;
    htc_resp_s  rs;
    htc_req_s   rq;
    logic       eff_mpu;
    logic [2:0] eff_route;
    logic [3:0] eff_dbg;
    logic       virq_dis;
    int         mismatches = 0;
    int         checks = 0;

    always #2 clk_i = ~clk_i;

    htc_trap_ctrl i_dut (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .req_i           (req),
        .system_control_reg_m_i       (system_control_reg_m),
        .route_ovr_i     (route_ovr),
        .dbg_trap_i      (dbg_trap),
        .resp_o          (resp),
        .eff_mpu_en_o    (eff_mpu),
        .eff_route_ovr_o (eff_route),
        .eff_dbg_trap_o  (eff_dbg),
        .virq_disable_o  (virq_dis)
    );

    htc_pipe_model i_pipe (
        .clk_i  (clk_i),
        .resp_i (resp),
        .req_o  (req)
    );

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Class bits: kernel_trap, coproc_access_control_reg, trace, fp sysreg, memctl
    function automatic htc_req_s mk(htc_op_e o, htc_level_e lv, logic [4:0] cls, logic rd);
        htc_req_s r;
        r = '0;
        r.valid = 1'h1;
        r.op = o;
        r.level = lv;
        r.is_read = rd;
        {r.kernel_trap, r.is_coproc_access_control_reg, r.is_trace, r.is_fp_sysreg, r.is_memctl} = cls;
        return r;
    endfunction

    function automatic htc_req_s mkreg(input logic cfg, input logic rd, input logic [31:0] d, input htc_level_e lv);
        htc_req_s r;
        r = mk(HTC_OP_SYSREG, lv, 5'h00, rd);
        r.enc = {FT_COPROC, FT_OPC1, FT_CRN, FT_CRM, cfg ? CFG_OPC2 : FT_OPC2};
        r.wdata = d;
        return r;
    endfunction

    task automatic acc(input logic cfg, input logic rd, input logic [31:0] d, input htc_level_e lv);
        i_pipe.send(mkreg(cfg, rd, d, lv), rs);
    endtask

    task automatic rd(input logic cfg, input logic [31:0] mask, input logic [31:0] exp);
        acc(cfg, 1'h1, 32'h0, HTC_HYP);
        cmp({31'h0, rs.rd_valid}, 32'h1);
        cmp(rs.rdata & mask, exp);
    endtask

    // Expected: hyp_trap, undef_hyp, undef_local, proceed; valid must stand with them
    task automatic opr(input htc_op_e o, input htc_level_e lv, input logic [4:0] cls, input logic rd,
                       input logic [3:0] exp);
        i_pipe.send(mk(o, lv, cls, rd), rs);
        cmp({27'h0, rs.valid, rs.hyp_trap, rs.undef_hyp, rs.undef_local, rs.proceed}, {27'h0, 1'h1, exp});
    endtask

    // Reads whenever the memory-control class bit is set
    task automatic op(input htc_op_e o, input htc_level_e lv, input logic [4:0] cls, input logic [3:0] exp);
        opr(o, lv, cls, cls[0], exp);
    endtask

    task automatic eff(input logic [8:0] exp);
        repeat (2) @(posedge clk_i);
        #1;
        cmp({23'h0, eff_mpu, eff_route, eff_dbg, virq_dis}, {23'h0, exp});
        cmp({31'h0, resp.valid}, 32'h0);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'h1;
        rd(1'h0, 32'hFFFF_FFFF, 32'h0000_33FF);
        rd(1'h1, 32'hFF00_0000, 32'h0000_0000);
        eff({1'h1, 3'h2, 4'h5, 1'h0});
        op(HTC_OP_FP, HTC_KERNEL, 5'h00, 4'h1);
        op(HTC_OP_NONE, HTC_KERNEL, 5'h00, 4'h1);
        op(HTC_OP_HVC, HTC_KERNEL, 5'h00, 4'h1);
        op(HTC_OP_HVC, HTC_USER, 5'h00, 4'h2);
        op(HTC_OP_POU_CMO, HTC_USER, 5'h00, 4'h2);
        acc(1'h0, 1'h1, 32'h0, HTC_KERNEL);
        cmp({30'h0, rs.undef_local, rs.suppress}, 32'h3);
        acc(1'h0, 1'h0, 32'hFFFF_FFFF, HTC_HYP);
        rd(1'h0, 32'hFFFF_FFFF, 32'h8010_BFFF);
        op(HTC_OP_FP, HTC_KERNEL, 5'h00, 4'h8);
        op(HTC_OP_FP, HTC_HYP, 5'h00, 4'h4);
        op(HTC_OP_VECTOR, HTC_USER, 5'h00, 4'h8);
        op(HTC_OP_FP, HTC_KERNEL, 5'h10, 4'h1);
        op(HTC_OP_SYSREG, HTC_KERNEL, 5'h08, 4'h8);
        op(HTC_OP_SYSREG, HTC_KERNEL, 5'h02, 4'h8);
        op(HTC_OP_SYSREG, HTC_HYP, 5'h04, 4'h4);
        op(HTC_OP_SYSREG, HTC_USER, 5'h05, 4'h8);
        cmp({31'h0, rs.suppress}, 32'h1);
        rq = mk(HTC_OP_SYSREG, HTC_USER, 5'h04, 1'h0);
        rq.trace_user_denied = 1'h1;
        i_pipe.send(rq, rs);
        cmp({28'h0, rs.hyp_trap, rs.undef_hyp, rs.undef_local, rs.proceed}, 32'h2);
        acc(1'h0, 1'h0, 32'h0000_8800, HTC_HYP);
        op(HTC_OP_VECTOR, HTC_KERNEL, 5'h00, 4'h8);
        op(HTC_OP_FP, HTC_KERNEL, 5'h00, 4'h1);
        op(HTC_OP_SYSREG, HTC_KERNEL, 5'h08, 4'h1);
        acc(1'h1, 1'h0, 32'hFFFF_FFFF, HTC_HYP);
        rd(1'h1, 32'hFF00_0000, 32'h6D00_0000);
        op(HTC_OP_SYSREG, HTC_KERNEL, 5'h01, 4'h8);
        opr(HTC_OP_SYSREG, HTC_KERNEL, 5'h01, 1'h0, 4'h8);
        op(HTC_OP_HVC, HTC_KERNEL, 5'h00, 4'h2);
        op(HTC_OP_HVC, HTC_HYP, 5'h00, 4'h2);
        op(HTC_OP_POU_CMO, HTC_KERNEL, 5'h00, 4'h8);
        op(HTC_OP_POU_CMO, HTC_USER, 5'h00, 4'h2);
        i_pipe.send(mk(HTC_OP_EXC_ROUTE, HTC_KERNEL, 5'h00, 1'h0), rs);
        cmp({31'h0, rs.route_hyp}, 32'h1);
        i_pipe.send(mk(HTC_OP_EXC_RET, HTC_HYP, 5'h00, 1'h0), rs);
        cmp({30'h0, rs.illegal_ret, rs.proceed}, 32'h2);
        eff({1'h0, 3'h7, 4'hF, 1'h1});
        acc(1'h1, 1'h0, 32'h4000_0000, HTC_HYP);
        i_pipe.send(mk(HTC_OP_EXC_ROUTE, HTC_KERNEL, 5'h00, 1'h0), rs);
        cmp({31'h0, rs.route_hyp}, 32'h0);
        opr(HTC_OP_SYSREG, HTC_KERNEL, 5'h01, 1'h0, 4'h1);
        op(HTC_OP_SYSREG, HTC_KERNEL, 5'h01, 4'h8);
        eff({1'h1, 3'h2, 4'h5, 1'h0});
        // Write then read on consecutive edges
        rq = mkreg(1'h0, 1'h0, 32'h0000_0400, HTC_HYP);
        i_pipe.send_pair(rq, mkreg(1'h0, 1'h1, 32'h0, HTC_HYP), rs);
        cmp({31'h0, rs.rd_valid}, 32'h1);
        cmp(rs.rdata, 32'h0000_37FF);
        // Reset again in mid-run: every trap field back to zero
        @(posedge clk_i);
        rst_n_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'h1;
        rd(1'h0, 32'hFFFF_FFFF, 32'h0000_33FF);
        rd(1'h1, 32'hFF00_0000, 32'h0000_0000);
        eff({1'h1, 3'h2, 4'h5, 1'h0});
        end_sim();
    end
endmodule
